// >>> src/bdc_ctrl_regs.sv
/*
 * Balance and diagnostic control register group: ten byte registers with
 * their decode into balancing, comparator, pull, filter path, open-wire
 * and correction test controls.
 * Assumes a synchronous byte register port from the host link logic, and
 * enable, pull configuration and data inputs synchronous to mclk.
 */
`timescale 1ns/1ps

module bdc_ctrl_regs #(
	parameter int DATA_W = 16,
	parameter int CRC_W = 16
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [bdc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic [5:0] auto_balance_req,
	input wire logic [5:0] cell_enable,
	input wire logic [5:0] pin_enable,
	input wire logic [17:0] pin_pull_config,
	input wire logic [CRC_W-1:0] crc_calc,
	input wire logic [DATA_W-1:0] cell_corrected,
	input wire logic [DATA_W-1:0] cell_uncorrected,
	input wire logic [DATA_W-1:0] cell_raw_single,
	input wire logic [DATA_W-1:0] cell_raw_filtered,
	input wire logic [DATA_W-1:0] aux_pin_one_single,
	input wire logic [DATA_W-1:0] aux_pin_one_filtered,
	output logic [12:0] finish_level,
	output logic balance_finished_compare,
	output logic [5:0] balance_switch_on,
	output logic filter_fault_inject,
	output logic aux_digital_fault_inject,
	output logic serial_master_loop_test,
	output logic [CRC_W-1:0] crc_sent,
	output bdc_pkg::bdc_cmp_sel_s volt_cmp,
	output bdc_pkg::bdc_cmp_sel_s temp_cmp,
	output logic aux_cell_active,
	output logic [2:0] aux_cell_latched,
	output logic [5:0] aux_factory_correction,
	output bdc_pkg::bdc_pull_s pin_pull,
	output logic [DATA_W-1:0] filter_in,
	output logic [DATA_W-1:0] cell_raw_result,
	output logic [DATA_W-1:0] aux_pin_one_result,
	output logic aux_continuous,
	output logic [6:0] sense_line_test_current,
	output logic [6:0] balance_line_test_current,
	output logic [5:0] balance_compare_enable,
	output logic correction_test_run,
	output logic encoder_test_run,
	output logic decoder_test_run,
	output logic correction_manual,
	output logic double_or_single_test_pick
);

	// ----------------------------------------------------------------
	// Register storage and port decode
	// ----------------------------------------------------------------
	logic [7:0] regs [bdc_pkg::REG_NUM];
	logic [bdc_pkg::REG_NUM-1:0] hit;
	logic [7:0] rd_mux;

	genvar gi;
	generate
		for (gi = 0; gi < bdc_pkg::REG_NUM; gi++)
		begin : g_reg
			assign hit[gi] = (reg_addr == bdc_pkg::REG_OFS[gi]);
			// Bits hold until rewritten; nothing here self-clears
			always_ff @(posedge mclk or negedge nrst)
			begin
				if (!nrst)
					regs[gi] <= bdc_pkg::REG_RST[gi];
				else if (reg_wr && hit[gi])
					regs[gi] <= reg_wdata & bdc_pkg::REG_MASK[gi];
			end
		end
	endgenerate

	// Unmapped addresses read as zero
	always_comb
	begin
		rd_mux = 8'h00;
		for (int i = 0; i < bdc_pkg::REG_NUM; i++)
			rd_mux = rd_mux | (hit[i] ? regs[i] : 8'h00);
	end

	// ----------------------------------------------------------------
	// Field views
	// ----------------------------------------------------------------
	wire logic [7:0] thr = regs[bdc_pkg::IDX_FINISH_LEVEL];
	wire logic [7:0] sw = regs[bdc_pkg::IDX_SWITCH];
	wire logic [7:0] d1 = regs[bdc_pkg::IDX_DIAG1];
	wire logic [7:0] d2 = regs[bdc_pkg::IDX_DIAG2];
	wire logic [7:0] d4 = regs[bdc_pkg::IDX_DIAG4];
	wire logic [7:0] ecc = regs[bdc_pkg::IDX_ECC];
	wire logic [5:0] thr_code = thr[bdc_pkg::THR_CODE_LSB +: 6];
	wire logic [2:0] pin_sel = d2[bdc_pkg::D2_PIN_LSB +: 3];
	wire logic [2:0] cell_sel = d2[bdc_pkg::D2_CELL_LSB +: 3];
	wire logic cell_sel_en = d2[bdc_pkg::D2_CELL_EN];
	wire logic [11:0] pull_ovr = {d4[3:0], regs[bdc_pkg::IDX_DIAG3]};

	// ----------------------------------------------------------------
	// Finish level
	// ----------------------------------------------------------------
	wire logic [12:0] next_finish_level = (thr_code >= bdc_pkg::LEVEL_CAP_CODE)
		? bdc_pkg::LEVEL_MAX_MV
		: bdc_pkg::LEVEL_BASE_MV + 13'(13'(thr_code) * bdc_pkg::LEVEL_STEP_MV);

	// ----------------------------------------------------------------
	// Balancing switches
	// ----------------------------------------------------------------
	wire logic [5:0] sw_source = sw[bdc_pkg::SW_CTRL] ? sw[5:0] : auto_balance_req;
	wire logic [5:0] next_switch_on = sw[bdc_pkg::SW_HOLD] ? 6'h00 : sw_source;

	// ----------------------------------------------------------------
	// Comparator modes
	// ----------------------------------------------------------------
	logic [5:0] cell_pick;
	logic [5:0] pin_pick;

	bdc_lowest_pick #(.W(6)) u_cell_pick (
		.enables(cell_enable),
		.pick(cell_pick)
	);

	bdc_lowest_pick #(.W(6)) u_pin_pick (
		.enables(pin_enable),
		.pick(pin_pick)
	);

	function automatic bdc_pkg::bdc_cmp_sel_s mode_decode(input logic [1:0] code,
		input logic [5:0] enables, input logic [5:0] lowest);
		bdc_pkg::bdc_cmp_sel_s s;
		s = '0;
		case (bdc_pkg::bdc_cmp_mode_e'(code))
			bdc_pkg::BDC_RR_TEST:
			begin
				s.round_robin = 1'b1;
				s.self_test = 1'b1;
				s.pick = enables;
			end
			bdc_pkg::BDC_RR_PLAIN:
			begin
				s.round_robin = 1'b1;
				s.pick = enables;
			end
			default:
			begin
				s.single = 1'b1;
				s.pick = lowest;
			end
		endcase
		return s;
	endfunction

	wire bdc_pkg::bdc_cmp_sel_s next_volt_cmp =
		mode_decode(d1[bdc_pkg::D1_VMODE_LSB +: 2], cell_enable, cell_pick);
	wire bdc_pkg::bdc_cmp_sel_s next_temp_cmp =
		mode_decode(d1[bdc_pkg::D1_TMODE_LSB +: 2], pin_enable, pin_pick);

	// ----------------------------------------------------------------
	// Aux selections
	// ----------------------------------------------------------------
	// Only a rising enable takes the selection; changes while it is set are
	// ignored, which is why the host must drop the enable first
	wire logic cell_sel_rise = reg_wr && hit[bdc_pkg::IDX_DIAG2]
		&& reg_wdata[bdc_pkg::D2_CELL_EN] && !cell_sel_en;
	logic [2:0] cell_hold;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			cell_hold <= 3'h0;
		else if (cell_sel_rise)
			cell_hold <= reg_wdata[bdc_pkg::D2_CELL_LSB +: 3];
	end

	wire logic [5:0] next_pin_hot = (pin_sel >= 3'h6) ? 6'h20
		: (pin_sel == 3'h0) ? 6'h00
		: 6'(6'h01 << (pin_sel - 3'h1));

	// ----------------------------------------------------------------
	// Pull overrides
	// ----------------------------------------------------------------
	wire bdc_pkg::bdc_pull_s next_pull;

	generate
		for (gi = 0; gi < 6; gi++)
		begin : g_pull
			wire logic analog = (pin_pull_config[3*gi +: 3] == bdc_pkg::PULL_ANALOG);
			wire logic [1:0] ovr = pull_ovr[2*gi +: 2];
			assign next_pull.up[gi] = analog && ovr[1];
			assign next_pull.down[gi] = analog && (ovr == 2'b01);
			assign next_pull.defer[gi] = !analog || (ovr == 2'b00);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Filter data paths
	// ----------------------------------------------------------------
	wire logic [DATA_W-1:0] next_filter_in =
		d4[bdc_pkg::D4_FILT_RAW] ? cell_uncorrected : cell_corrected;
	wire logic [DATA_W-1:0] next_cell_raw =
		d4[bdc_pkg::D4_CELL_VIEW] ? cell_raw_filtered : cell_raw_single;
	wire logic [DATA_W-1:0] next_aux_one =
		d4[bdc_pkg::D4_AUX_VIEW] ? aux_pin_one_filtered : aux_pin_one_single;

	wire logic [CRC_W-1:0] next_crc =
		d1[bdc_pkg::D1_INVERT] ? ~crc_calc : crc_calc;

	// ----------------------------------------------------------------
	// Output flops
	// ----------------------------------------------------------------
	// Read data is zero outside the answer cycle
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
			reg_rvalid <= reg_rd;
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			finish_level <= 13'h0000;
			balance_finished_compare <= 1'b0;
			balance_switch_on <= 6'h00;
		end
		else
		begin
			finish_level <= next_finish_level;
			balance_finished_compare <= thr[bdc_pkg::THR_ENABLE];
			balance_switch_on <= next_switch_on;
		end
	end

	// Diagnostic controls
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			filter_fault_inject <= 1'b0;
			aux_digital_fault_inject <= 1'b0;
			serial_master_loop_test <= 1'b0;
			crc_sent <= '0;
			volt_cmp <= '0;
			temp_cmp <= '0;
			aux_cell_active <= 1'b0;
			aux_cell_latched <= 3'h0;
			aux_factory_correction <= 6'h00;
			pin_pull <= '0;
		end
		else
		begin
			filter_fault_inject <= d1[bdc_pkg::D1_FILT_INJ];
			aux_digital_fault_inject <= d1[bdc_pkg::D1_AUX_INJ];
			serial_master_loop_test <= d1[bdc_pkg::D1_LOOP];
			crc_sent <= next_crc;
			volt_cmp <= next_volt_cmp;
			temp_cmp <= next_temp_cmp;
			aux_cell_active <= cell_sel_en && (cell_hold != 3'h0);
			aux_cell_latched <= cell_sel_en ? cell_hold : 3'h0;
			aux_factory_correction <= next_pin_hot;
			pin_pull <= next_pull;
		end
	end

	// Data path selects, one edge behind their inputs
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			filter_in <= '0;
			cell_raw_result <= '0;
			aux_pin_one_result <= '0;
			aux_continuous <= 1'b0;
		end
		else
		begin
			filter_in <= next_filter_in;
			cell_raw_result <= next_cell_raw;
			aux_pin_one_result <= next_aux_one;
			aux_continuous <= d4[bdc_pkg::D4_AUX_VIEW];
		end
	end

	// Open-wire sinks and correction test, none self-clearing
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			sense_line_test_current <= 7'h00;
			balance_line_test_current <= 7'h00;
			balance_compare_enable <= 6'h00;
			correction_test_run <= 1'b0;
			encoder_test_run <= 1'b0;
			decoder_test_run <= 1'b0;
			correction_manual <= 1'b0;
			double_or_single_test_pick <= 1'b0;
		end
		else
		begin
			sense_line_test_current <= regs[bdc_pkg::IDX_SENSE_CS][6:0];
			balance_line_test_current <= regs[bdc_pkg::IDX_BAL_CS][6:0];
			balance_compare_enable <= regs[bdc_pkg::IDX_COMP][5:0];
			correction_test_run <= ecc[bdc_pkg::ECC_EN];
			encoder_test_run <= ecc[bdc_pkg::ECC_EN] && ecc[bdc_pkg::ECC_DIR];
			decoder_test_run <= ecc[bdc_pkg::ECC_EN] && !ecc[bdc_pkg::ECC_DIR];
			correction_manual <= ecc[bdc_pkg::ECC_MANUAL];
			double_or_single_test_pick <= ecc[bdc_pkg::ECC_PICK];
		end
	end

endmodule

// >>> src/bdc_pkg.sv
/*
 * Constants, register map and carrier types for the balance and diagnostic
 * control register group.
 * Assumes a byte-wide register port whose address carries the full
 * register offset.
 */
package bdc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int REG_NUM = 10;
	localparam int ADDR_W = 16;

	localparam int IDX_FINISH_LEVEL = 0;
	localparam int IDX_SWITCH = 1;
	localparam int IDX_DIAG1 = 2;
	localparam int IDX_DIAG2 = 3;
	localparam int IDX_DIAG3 = 4;
	localparam int IDX_DIAG4 = 5;
	localparam int IDX_SENSE_CS = 6;
	localparam int IDX_BAL_CS = 7;
	localparam int IDX_COMP = 8;
	localparam int IDX_ECC = 9;

	localparam logic [ADDR_W-1:0] REG_OFS [REG_NUM] = '{
		16'h0114, 16'h0115, 16'h0116, 16'h0117, 16'h0118,
		16'h0119, 16'h011A, 16'h011B, 16'h011C, 16'h011D
	};

	// Reserved bits neither store nor read back
	localparam logic [7:0] REG_MASK [REG_NUM] = '{
		8'h7F, 8'hFF, 8'hFF, 8'h7F, 8'hFF,
		8'h7F, 8'h7F, 8'h7F, 8'h3F, 8'h0F
	};

	localparam logic [7:0] REG_RST [REG_NUM] = '{
		8'h20, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00
	};

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int THR_CODE_LSB = 0;
	localparam int THR_ENABLE = 6;
	localparam int SW_CTRL = 7;
	localparam int SW_HOLD = 6;
	localparam int D1_FILT_INJ = 7;
	localparam int D1_AUX_INJ = 6;
	localparam int D1_LOOP = 5;
	localparam int D1_INVERT = 4;
	localparam int D1_VMODE_LSB = 2;
	localparam int D1_TMODE_LSB = 0;
	localparam int D2_CELL_EN = 6;
	localparam int D2_PIN_LSB = 3;
	localparam int D2_CELL_LSB = 0;
	localparam int D4_FILT_RAW = 6;
	localparam int D4_CELL_VIEW = 5;
	localparam int D4_AUX_VIEW = 4;
	localparam int ECC_PICK = 3;
	localparam int ECC_MANUAL = 2;
	localparam int ECC_DIR = 1;
	localparam int ECC_EN = 0;

	// ----------------------------------------------------------------
	// Finish level scale, millivolts, and analog pull code
	// ----------------------------------------------------------------
	localparam logic [12:0] LEVEL_BASE_MV = 13'h0AF0;
	localparam logic [12:0] LEVEL_STEP_MV = 13'h0019;
	localparam logic [12:0] LEVEL_MAX_MV = 13'h10CC;
	localparam logic [5:0] LEVEL_CAP_CODE = 6'h3C;
	localparam logic [2:0] PULL_ANALOG = 3'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BDC_RR_TEST = 2'b00,
		BDC_RR_PLAIN = 2'b01,
		BDC_SINGLE_A = 2'b10,
		BDC_SINGLE_B = 2'b11
	} bdc_cmp_mode_e;

	typedef struct packed {
		logic round_robin;
		logic self_test;
		logic single;
		logic [5:0] pick;
	} bdc_cmp_sel_s;

	typedef struct packed {
		logic [5:0] up;
		logic [5:0] down;
		logic [5:0] defer;
	} bdc_pull_s;

endpackage

// >>> src/bdc_lowest_pick.sv
/*
 * One-hot pick of the lowest set bit of an enable vector.
 * Assumes nothing of its surroundings; purely combinational.
 */
`timescale 1ns/1ps
module bdc_lowest_pick #(
	parameter int W = 6
) (
	input wire logic [W-1:0] enables,
	output logic [W-1:0] pick
);

	// Two's complement isolates the lowest one
	assign pick = enables & (~enables + {{(W-1){1'b0}}, 1'b1});

endmodule

// >>> tb/bdc_props_chk_props.sv
/*
 * Concurrent checks on the balance and diagnostic control register group.
 * Assumes it is bound to bdc_ctrl_regs and sees only that module's ports.
 */
`timescale 1ns/1ps
module bdc_props_chk #(
	parameter int DATA_W = 16,
	parameter int CRC_W = 16
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rvalid,
	input wire logic [CRC_W-1:0] crc_calc,
	input wire logic [CRC_W-1:0] crc_sent,
	input wire logic [12:0] finish_level,
	input wire logic [5:0] balance_switch_on,
	input wire logic [DATA_W-1:0] cell_corrected,
	input wire logic [DATA_W-1:0] cell_uncorrected,
	input wire logic [DATA_W-1:0] filter_in,
	input wire logic aux_continuous,
	input wire bdc_pkg::bdc_cmp_sel_s volt_cmp,
	input wire bdc_pkg::bdc_cmp_sel_s temp_cmp,
	input wire logic correction_test_run,
	input wire logic encoder_test_run,
	input wire logic decoder_test_run
);
	// ----------------------------------------------------------------
	// Register mirror
	// ----------------------------------------------------------------
	// Outputs lag their register by one edge, so checks use $past
	logic live;
	logic [7:0] s114, s115, s116, s119, s11d;
	logic [12:0] exp_lvl;
	assign exp_lvl = (s114[5:0] >= 6'h3C) ? 13'h10CC : 13'h0AF0 + 13'h0019 * {7'h00, s114[5:0]};
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			live <= 1'b0;
			s114 <= 8'h20;
			s115 <= 8'h00;
			s116 <= 8'h00;
			s119 <= 8'h00;
			s11d <= 8'h00;
		end
		else
		begin
			live <= 1'b1;
			if (reg_wr && reg_addr == 16'h0114) s114 <= reg_wdata;
			if (reg_wr && reg_addr == 16'h0115) s115 <= reg_wdata;
			if (reg_wr && reg_addr == 16'h0116) s116 <= reg_wdata;
			if (reg_wr && reg_addr == 16'h0119) s119 <= reg_wdata;
			if (reg_wr && reg_addr == 16'h011D) s11d <= reg_wdata;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);

	a_level_scale: assert property (
		live |-> finish_level == $past(exp_lvl)) else $error("finish level wrong");
	a_hold_blocks_switch: assert property (
		live && $past(s115[6]) |-> balance_switch_on == 6'h00) else $error("hold ignored");
	a_soft_switch_drive: assert property (
		live && $past(s115[7:6]) == 2'b10 |-> balance_switch_on == $past(s115[5:0]))
		else $error("software switch wrong");
	a_crc_invert_sent: assert property (
		live |-> crc_sent == ($past(s116[4]) ? ~$past(crc_calc) : $past(crc_calc)))
		else $error("sent check wrong");
	a_volt_mode_map: assert property (
		live |-> volt_cmp.single == $past(s116[3]) && volt_cmp.round_robin != volt_cmp.single
		&& volt_cmp.self_test == ($past(s116[3:2]) == 2'b00)) else $error("volt mode wrong");
	a_temp_mode_map: assert property (
		live |-> temp_cmp.single == $past(s116[1]) && temp_cmp.round_robin != temp_cmp.single
		&& temp_cmp.self_test == ($past(s116[1:0]) == 2'b00)) else $error("temp mode wrong");
	a_filter_src_pick: assert property (
		live |-> filter_in == ($past(s119[6]) ? $past(cell_uncorrected) : $past(cell_corrected)))
		else $error("filter source wrong");
	a_aux_cont_mode: assert property (
		live |-> aux_continuous == $past(s119[4])) else $error("aux mode wrong");
	// Output trails the register by an edge, so a host clear must not count
	a_test_stays_on: assert property (
		correction_test_run && s11d[0] |=> correction_test_run)
		else $error("test enable cleared");
	a_coder_dir_run: assert property (
		live |-> encoder_test_run == (&$past(s11d[1:0]))
		&& decoder_test_run == ($past(s11d[1:0]) == 2'b01)) else $error("coder test wrong");
	a_read_one_cycle: assert property (
		live |-> reg_rvalid == $past(reg_rd)) else $error("read answer wrong");

	c_read: cover property (reg_rd ##1 reg_rvalid);
	c_encoder: cover property (encoder_test_run);
	c_hold: cover property (balance_switch_on != 6'h00 ##1 balance_switch_on == 6'h00);
endmodule

bind bdc_ctrl_regs bdc_props_chk #(.DATA_W(DATA_W), .CRC_W(CRC_W)) u_props (.mclk, .nrst,
	.reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rvalid, .crc_calc, .crc_sent,
	.finish_level, .balance_switch_on, .cell_corrected, .cell_uncorrected, .filter_in,
	.aux_continuous, .volt_cmp, .temp_cmp, .correction_test_run, .encoder_test_run,
	.decoder_test_run);

// >>> tb/balance_diag_ctrl_regs_bench.sv
/*
 * Self-checking bench for the balance and diagnostic control registers.
 * Assumes the design and checker are compiled first; drives at negedge.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module balance_diag_ctrl_regs_bench;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [5:0] auto_balance_req = 6'h15;
	logic [5:0] cell_enable = 6'h2C;
	logic [5:0] pin_enable = 6'h12;
	logic [17:0] pin_pull_config = 18'h0_9000;
	logic [15:0] crc_calc = 16'hA5C3;
	logic [15:0] cell_corrected = 16'h1111, cell_uncorrected = 16'h2222;
	logic [15:0] cell_raw_single = 16'h3333, cell_raw_filtered = 16'h4444;
	logic [15:0] aux_pin_one_single = 16'h5555, aux_pin_one_filtered = 16'h6666;
	logic [7:0] reg_rdata;
	logic reg_rvalid, balance_finished_compare, filter_fault_inject, aux_digital_fault_inject;
	logic serial_master_loop_test, aux_cell_active, aux_continuous, correction_test_run;
	logic encoder_test_run, decoder_test_run, correction_manual, double_or_single_test_pick;
	logic [12:0] finish_level;
	logic [5:0] balance_switch_on, aux_factory_correction, balance_compare_enable;
	logic [15:0] crc_sent, filter_in, cell_raw_result, aux_pin_one_result;
	logic [2:0] aux_cell_latched;
	logic [6:0] sense_line_test_current, balance_line_test_current;
	bdc_pkg::bdc_cmp_sel_s volt_cmp, temp_cmp;
	bdc_pkg::bdc_pull_s pin_pull;
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;

	bdc_ctrl_regs DUT (.mclk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.reg_rvalid, .auto_balance_req, .cell_enable, .pin_enable, .pin_pull_config,
		.crc_calc, .cell_corrected, .cell_uncorrected, .cell_raw_single, .cell_raw_filtered,
		.aux_pin_one_single, .aux_pin_one_filtered, .finish_level, .balance_finished_compare,
		.balance_switch_on, .filter_fault_inject, .aux_digital_fault_inject,
		.serial_master_loop_test, .crc_sent, .volt_cmp, .temp_cmp, .aux_cell_active,
		.aux_cell_latched, .aux_factory_correction, .pin_pull, .filter_in, .cell_raw_result,
		.aux_pin_one_result, .aux_continuous, .sense_line_test_current,
		.balance_line_test_current, .balance_compare_enable, .correction_test_run,
		.encoder_test_run, .decoder_test_run, .correction_manual, .double_or_single_test_pick);

	always #50 mclk = ~mclk;

	// ----------------------------------------------------------------
	// Register port tasks
	// ----------------------------------------------------------------
	// Write leaves one spare edge so decoded outputs have landed
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
		@(negedge mclk);
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		`CHK(reg_rvalid, 1'b1)
		`CHK(reg_rdata, e)
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regmap();
		for (int i = 0; i < bdc_pkg::REG_NUM; i++)
			rd(bdc_pkg::REG_OFS[i], bdc_pkg::REG_RST[i]);
		`CHK(finish_level, 13'h0E10)
		`CHK({sense_line_test_current, balance_line_test_current}, 14'h0000)
		for (int i = 0; i < bdc_pkg::REG_NUM; i++)
		begin
			wr(bdc_pkg::REG_OFS[i], 8'hFF);
			rd(bdc_pkg::REG_OFS[i], bdc_pkg::REG_MASK[i]);
			wr(bdc_pkg::REG_OFS[i], 8'h00);
		end
		wr(16'h0113, 8'hFF);
		rd(16'h0113, 8'h00);
		rd(16'h011E, 8'h00);
	endtask

	task automatic t_level();
		logic [5:0] c [5] = '{6'h00, 6'h01, 6'h3B, 6'h3C, 6'h3F};
		logic [12:0] e;
		for (int i = 0; i < 5; i++)
		begin
			wr(16'h0114, {2'b01, c[i]});
			e = (c[i] >= 6'h3C) ? 13'h10CC : 13'h0AF0 + 13'h0019 * {7'h00, c[i]};
			`CHK(finish_level, e)
			`CHK(balance_finished_compare, 1'b1)
		end
		wr(16'h0114, 8'h3F);
		`CHK(balance_finished_compare, 1'b0)
	endtask

	task automatic t_switch();
		logic [7:0] w [5] = '{8'h00, 8'hAA, 8'hEA, 8'h40, 8'h00};
		logic [5:0] e [5] = '{6'h15, 6'h2A, 6'h00, 6'h00, 6'h15};
		for (int i = 0; i < 5; i++)
		begin
			wr(16'h0115, w[i]);
			`CHK(balance_switch_on, e[i])
		end
	endtask

	task automatic t_crc_mode();
		bdc_pkg::bdc_cmp_sel_s ev;
		bdc_pkg::bdc_cmp_sel_s et;
		wr(16'h0116, 8'hF0);
		`CHK(crc_sent, 16'h5A3C)
		`CHK({filter_fault_inject, aux_digital_fault_inject, serial_master_loop_test}, 3'h7)
		for (int m = 0; m < 4; m++)
		begin
			wr(16'h0116, 8'(m * 5));
			ev = {m < 2, m == 0, m > 1, (m > 1) ? 6'h04 : 6'h2C};
			et = {m < 2, m == 0, m > 1, (m > 1) ? 6'h02 : 6'h12};
			`CHK(volt_cmp, ev)
			`CHK(temp_cmp, et)
		end
		wr(16'h0116, 8'h00);
		`CHK(crc_sent, 16'hA5C3)
	endtask

	task automatic t_aux();
		logic [5:0] e;
		for (int s = 0; s < 8; s++)
		begin
			wr(16'h0117, 8'(s * 8));
			e = (s == 0) ? 6'h00 : (s > 5) ? 6'h20 : 6'(1 << (s - 1));
			`CHK(aux_factory_correction, e)
		end
		wr(16'h0117, 8'h43);
		`CHK({aux_cell_active, aux_cell_latched}, 4'hB)
		wr(16'h0117, 8'h45);
		`CHK(aux_cell_latched, 3'h3)
		wr(16'h0117, 8'h05);
		`CHK({aux_cell_active, aux_cell_latched}, 4'h0)
		wr(16'h0117, 8'h45);
		`CHK(aux_cell_latched, 3'h5)
		wr(16'h0117, 8'h00);
	endtask

	task automatic t_pull_path();
		wr(16'h0118, 8'hE4);
		wr(16'h0119, 8'h75);
		`CHK(pin_pull, {6'h0C, 6'h02, 6'h31})
		`CHK(filter_in, 16'h2222)
		`CHK(cell_raw_result, 16'h4444)
		`CHK(aux_pin_one_result, 16'h6666)
		`CHK(aux_continuous, 1'b1)
		pin_pull_config = 18'h0_0000;
		repeat (2) @(negedge mclk);
		`CHK(pin_pull, {6'h0C, 6'h32, 6'h01})
		wr(16'h0119, 8'h00);
		`CHK({filter_in, cell_raw_result, aux_pin_one_result}, 48'h1111_3333_5555)
		`CHK(aux_continuous, 1'b0)
	endtask

	task automatic t_sink_ecc();
		wr(16'h011A, 8'hFF);
		wr(16'h011B, 8'h55);
		wr(16'h011C, 8'hFF);
		`CHK({sense_line_test_current, balance_line_test_current}, 14'h3FD5)
		`CHK(balance_compare_enable, 6'h3F)
		wr(16'h011C, 8'h00);
		`CHK(balance_compare_enable, 6'h00)
		wr(16'h011D, 8'h03);
		`CHK({correction_test_run, encoder_test_run, decoder_test_run}, 3'b110)
		repeat (20) @(negedge mclk);
		`CHK(correction_test_run, 1'b1)
		wr(16'h011D, 8'h01);
		`CHK({correction_test_run, encoder_test_run, decoder_test_run}, 3'b101)
		wr(16'h011D, 8'h0C);
		`CHK({correction_test_run, correction_manual, double_or_single_test_pick}, 3'b011)
	endtask

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	task automatic close_out();
		$display("checks=%0d errors=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Whole run needs about 260 cycles
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errors++;
			close_out();
		end
	end

	initial
	begin
		repeat (8) @(negedge mclk);
		nrst = 1'b1;
		t_regmap();
		t_level();
		t_switch();
		t_crc_mode();
		t_aux();
		t_pull_path();
		t_sink_ecc();
		close_out();
	end
endmodule
